// *** can_ctrl_pkg.sv ***
// Shared constants and types for the CAN interrupt enable and operating-mode block
package can_ctrl_pkg;

	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int REG_W   = 16;
	localparam int NUM_CAN = 2;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFFSET = 8'h48;
	localparam logic [ADDR_W-1:0] IRQ_FLAGS_OFFSET  = 8'h60;
	localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFFSET  = 8'h64;
	localparam logic [ADDR_W-1:0] OP_MODE_BASE      = 8'h68;
	localparam logic [ADDR_W-1:0] REG_STRIDE        = 8'h04;

	// Flag and enable bit layout (shared by flags, clear and enable)
	localparam int RX_MSG_BIT      = 15;
	localparam int TX_AVAIL_BIT    = 14;
	localparam int GLOBAL_GATE_BIT = 0;

	localparam logic [REG_W-1:0] TRAFFIC_MASK  = 16'hF810;
	localparam logic [REG_W-1:0] ERROR_MASK    = 16'h07E0;
	localparam logic [REG_W-1:0] DIAG_MASK     = 16'h000C;
	localparam logic [REG_W-1:0] TX_DONE_MASK  = 16'h3800;
	localparam logic [REG_W-1:0] TX_AVAIL_MASK = 16'h4000;
	localparam logic [REG_W-1:0] FLAG_MASK     = 16'hFFFC;
	localparam logic [REG_W-1:0] EN_WRITABLE   = 16'hFFFD;
	localparam logic [REG_W-1:0] MODE_WRITABLE = 16'h0007;

	// Reset values
	localparam logic [REG_W-1:0]  ENABLE_RESET = 16'h0000;
	localparam logic [REG_W-1:0]  FLAGS_RESET  = 16'h0000;
	localparam logic [REG_W-1:0]  MODE_RESET   = 16'h0000;
	localparam logic [REG_W-1:0]  REG_ZERO     = 16'h0000;
	localparam logic [DATA_W-1:0] RDATA_RESET  = 32'h0000_0000;

	// Bus level driven while not transmitting
	localparam logic RECESSIVE = 1'b1;

	typedef struct packed {
		logic [12:0] reserved;
		logic        loop_back;
		logic        passive;
		logic        run;
	} mode_s;

	typedef struct packed {
		logic traffic;
		logic error;
		logic diag;
	} irq_groups_s;

endpackage : can_ctrl_pkg

// *** can_irq_mode_ctrl.sv ***
// CAN interrupt flags, enables, group outputs and operating-mode routing
//
// Functional notes
// - Sources sorted into traffic, error, diagnostic groups
// - Source counts only when enabled; bit0 gates all
// - Enable bit 15 gates receive-available into traffic
// - Bits 14..11 gate transmit sources into traffic
// - Enable bit 4 gates overrun into traffic
// - Bits 10..5 gate error sources into error
// - Bits 3,2 gate diagnostic; bit 1 reserved
// - Transmit disabled gives pure listener operation
// - Mode bit 2 loops modules internally
// - Mode bit 1 holds transmit recessive
// - Mode bit 0 runs or stops; reads state
// - Second module loopback bit has no effect
// - Flags set by event, cleared writing one
// - Clearing available and done flags clear each other
`timescale 1ns/1ps

module can_irq_mode_ctrl (
	// APB slave
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [can_ctrl_pkg::ADDR_W-1:0]      paddr,
	input  wire logic [can_ctrl_pkg::DATA_W-1:0]      pwdata,
	output logic      [can_ctrl_pkg::DATA_W-1:0]      prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	// Events from the protocol core, one-cycle pulses
	input  wire logic [can_ctrl_pkg::REG_W-1:0]       flag_events,
	// Protocol core side, per module
	input  wire logic [can_ctrl_pkg::NUM_CAN-1:0]     core_tx,
	output logic      [can_ctrl_pkg::NUM_CAN-1:0]     core_rx,
	// Bus pins, per module
	input  wire logic [can_ctrl_pkg::NUM_CAN-1:0]     can_rx_pin,
	output logic      [can_ctrl_pkg::NUM_CAN-1:0]     can_tx_pin,
	// Mode state per module
	output can_ctrl_pkg::mode_s [can_ctrl_pkg::NUM_CAN-1:0] mode_state,
	// Interrupts
	output logic                                      traffic_irq_n,
	output logic                                      error_irq_n,
	output logic                                      diag_irq_n,
	output logic                                      irq
);
	import can_ctrl_pkg::*;

	logic [REG_W-1:0]          irq_enable;
	logic [REG_W-1:0]          irq_flags;
	mode_s [NUM_CAN-1:0]       op_mode;
	logic [REG_W-1:0]          wdata16;
	logic [REG_W-1:0]          clear_req;
	logic [REG_W-1:0]          next_flags;
	logic [DATA_W-1:0]         read_value;
	logic                      setup_phase;
	logic                      wr_access;
	logic                      loop_on;
	logic                      loop_bus;
	logic [NUM_CAN-1:0]        tx_eff;
	logic [NUM_CAN-1:0]        rx_meta;
	logic [NUM_CAN-1:0]        rx_sync;
	irq_groups_s               groups;

	// Byte address of a module's operating-mode register
	function automatic logic [ADDR_W-1:0] mode_offset(input int unsigned k);
		mode_offset = OP_MODE_BASE + ADDR_W'(k * REG_STRIDE);
	endfunction : mode_offset

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		if (a == IRQ_ENABLE_OFFSET) begin
			addr_mapped = 1'b1;
		end else if (a == IRQ_FLAGS_OFFSET) begin
			addr_mapped = 1'b1;
		end else if (a == IRQ_CLEAR_OFFSET) begin
			addr_mapped = 1'b1;
		end else if (a == mode_offset(0)) begin
			addr_mapped = 1'b1;
		end else if (a == mode_offset(1)) begin
			addr_mapped = 1'b1;
		end else begin
			addr_mapped = 1'b0;
		end
	endfunction : addr_mapped

	// Acknowledging transmit-available and any transmit-done are tied together
	function automatic logic [REG_W-1:0] expand_clear(input logic [REG_W-1:0] c);
		logic [REG_W-1:0] r;
		r = c & FLAG_MASK;
		if (|(c & TX_AVAIL_MASK)) begin
			r = r | TX_DONE_MASK;
		end
		if (|(c & TX_DONE_MASK)) begin
			r = r | TX_AVAIL_MASK;
		end
		expand_clear = r;
	endfunction : expand_clear

	// A group fires only through the general gate and its own enables
	function automatic logic group_hit(input logic [REG_W-1:0] flags,
	                                   input logic [REG_W-1:0] en,
	                                   input logic [REG_W-1:0] mask);
		group_hit = en[GLOBAL_GATE_BIT] & (|(flags & en & mask));
	endfunction : group_hit

	// APB decode; zero wait states
	assign pready      = 1'b1;
	assign setup_phase = psel & ~penable;
	assign wr_access   = psel & penable & pwrite;
	assign pslverr     = psel & penable & ~addr_mapped(paddr);
	assign wdata16     = pwdata[REG_W-1:0];

	always_comb begin
		clear_req = REG_ZERO;
		if (wr_access && (paddr == IRQ_CLEAR_OFFSET || paddr == IRQ_FLAGS_OFFSET)) begin
			clear_req = expand_clear(wdata16);
		end
	end

	// A new event in the clearing cycle wins over the clear
	assign next_flags = (irq_flags & ~clear_req) | (flag_events & FLAG_MASK);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_flags <= FLAGS_RESET;
		end else begin
			irq_flags <= next_flags;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable <= ENABLE_RESET;
		end else if (wr_access && paddr == IRQ_ENABLE_OFFSET) begin
			irq_enable <= wdata16 & EN_WRITABLE;
		end
	end

	// Read mux; the clear register is write-only and reads zero
	always_comb begin
		read_value = RDATA_RESET;
		if (paddr == IRQ_ENABLE_OFFSET) begin
			read_value[REG_W-1:0] = irq_enable;
		end else if (paddr == IRQ_FLAGS_OFFSET) begin
			read_value[REG_W-1:0] = irq_flags;
		end else if (paddr == mode_offset(0)) begin
			read_value[REG_W-1:0] = op_mode[0];
		end else if (paddr == mode_offset(1)) begin
			read_value[REG_W-1:0] = op_mode[1];
		end
	end

	// Read data captured in the setup phase so it is stable in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= RDATA_RESET;
		end else if (setup_phase && !pwrite) begin
			prdata <= read_value;
		end
	end

	// Group grouping: traffic holds 15,14,13..11 and overrun; error 10..5; diag 3,2
	always_comb begin
		groups.traffic = group_hit(irq_flags, irq_enable, TRAFFIC_MASK);
		groups.error   = group_hit(irq_flags, irq_enable, ERROR_MASK);
		groups.diag    = group_hit(irq_flags, irq_enable, DIAG_MASK);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			traffic_irq_n <= 1'b1;
			error_irq_n   <= 1'b1;
			diag_irq_n    <= 1'b1;
			irq           <= 1'b0;
		end else begin
			traffic_irq_n <= ~groups.traffic;
			error_irq_n   <= ~groups.error;
			diag_irq_n    <= ~groups.diag;
			irq           <= |groups;
		end
	end

	// Only the first module's loopback bit steers the routing
	assign loop_on  = op_mode[0].loop_back;
	// Looped modules share one wired-AND bus: dominant from either wins
	assign loop_bus = &tx_eff;
	assign mode_state = op_mode;

	genvar k;
	generate
		for (k = 0; k < NUM_CAN; k++) begin : g_chan
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					op_mode[k] <= mode_s'(MODE_RESET);
				end else if (wr_access && paddr == mode_offset(k)) begin
					op_mode[k] <= mode_s'(wdata16 & MODE_WRITABLE);
				end
			end

			// Passive or stopped modules never drive dominant, so they only listen
			assign tx_eff[k] = (op_mode[k].passive || !op_mode[k].run) ? RECESSIVE : core_tx[k];

			// Pin synchroniser; first stage feeds only the second
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rx_meta[k] <= RECESSIVE;
					rx_sync[k] <= RECESSIVE;
				end else begin
					rx_meta[k] <= can_rx_pin[k];
					rx_sync[k] <= rx_meta[k];
				end
			end

			// Loopback isolates the pins at recessive (a-c); else each uses its own pins
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					can_tx_pin[k] <= RECESSIVE;
					core_rx[k]    <= RECESSIVE;
				end else if (loop_on) begin
					can_tx_pin[k] <= RECESSIVE;
					core_rx[k]    <= loop_bus;
				end else begin
					can_tx_pin[k] <= tx_eff[k];
					core_rx[k]    <= rx_sync[k];
				end
			end
		end
	endgenerate

endmodule : can_irq_mode_ctrl

// *** can_irq_mode_chk.sv ***
// Assertion checker for the CAN interrupt enable and operating-mode block
`timescale 1ns/1ps
module can_irq_mode_chk (
	// Bus and events
	input wire logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata, prdata,
	input wire logic [15:0]            flag_events,
	// Link and mode
	input wire logic [1:0]             core_tx, core_rx, can_rx_pin, can_tx_pin,
	input wire can_ctrl_pkg::mode_s [1:0] mode_state,
	// Interrupts
	input wire logic                   traffic_irq_n, error_irq_n, diag_irq_n, irq
);
	import can_ctrl_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic       acc = psel && penable;
	// Recessive unless running and active
	wire logic [1:0] eff = core_tx | ~{mode_state[1].run, mode_state[0].run} | {mode_state[1].passive, mode_state[0].passive};
	sequence clr_quiet;
		acc && pwrite && paddr == IRQ_CLEAR_OFFSET && pwdata[15:2] == 14'h3FFF && flag_events == 16'h0000
			##1 flag_events == 16'h0000;
	endsequence
	AST_CLEAR_ALL: assert property (clr_quiet |=> traffic_irq_n && error_irq_n && diag_irq_n)
		else $error("group irq low after clearing every flag");
	AST_GATE_OFF: assert property (acc && pwrite && paddr == IRQ_ENABLE_OFFSET && !pwdata[0]
		|=> ##1 traffic_irq_n && error_irq_n && diag_irq_n) else $error("irq not gated by general enable");
	AST_IRQ_OR: assert property (irq == !(traffic_irq_n && error_irq_n && diag_irq_n))
		else $error("irq differs from group outputs");
	AST_LOOP_PINS: assert property (mode_state[0].loop_back |=> can_tx_pin == 2'b11)
		else $error("bus pins driven in loopback");
	AST_LOOP_RX: assert property (mode_state[0].loop_back |=> core_rx == {2{&$past(eff)}})
		else $error("loopback receive wrong");
	AST_TX_FOLLOW0: assert property (mode_state[0].run && !mode_state[0].passive && !mode_state[0].loop_back
		|=> can_tx_pin[0] == $past(core_tx[0])) else $error("module 0 pin not following core");
	AST_TX_FOLLOW1: assert property (mode_state[1].run && !mode_state[1].passive && !mode_state[0].loop_back
		|=> can_tx_pin[1] == $past(core_tx[1])) else $error("module 1 pin not following core");
	AST_QUIET_TX: assert property (!mode_state[0].run || mode_state[0].passive |=> can_tx_pin[0])
		else $error("stopped or passive module drives dominant");
	AST_RUN_READ: assert property (acc && !pwrite && paddr == OP_MODE_BASE |-> prdata[2:0] == mode_state[0][2:0])
		else $error("mode read differs from state");
endmodule : can_irq_mode_chk
bind can_irq_mode_ctrl can_irq_mode_chk u_can_irq_mode_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
	.pslverr, .paddr, .pwdata, .prdata, .flag_events, .core_tx, .core_rx, .can_rx_pin, .can_tx_pin, .mode_state,
	.traffic_irq_n, .error_irq_n, .diag_irq_n, .irq);

// *** can_bus_node.sv ***
// Far-side CAN bus: one wired-AND line per module with another node able to drive dominant
`timescale 1ns/1ps
module can_bus_node (
	input  wire logic [1:0] tx_pin,
	input  wire logic [1:0] node_dom,
	output logic      [1:0] rx_pin
);
	// Line pulls recessive; any dominant driver wins
	assign rx_pin = tx_pin & ~node_dom;
endmodule : can_bus_node

// *** can_irq_mode_ctrl_bench.sv ***
// Testbench for the CAN interrupt enable and operating-mode block
`timescale 1ns/1ps
module can_irq_mode_ctrl_bench;
	import can_ctrl_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, traffic_irq_n, error_irq_n, diag_irq_n, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        err;
	logic [15:0] flag_events;
	logic [1:0]  core_tx, core_rx, can_rx_pin, can_tx_pin, node_dom;
	logic [2:0]  exp3;
	mode_s [1:0] mode_state;
	int          fails, checked;
	wire logic [2:0] irqs = {traffic_irq_n, error_irq_n, diag_irq_n};
	can_irq_mode_ctrl u_can_irq_mode_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .flag_events, .core_tx, .core_rx, .can_rx_pin, .can_tx_pin, .mode_state,
		.traffic_irq_n, .error_irq_n, .diag_irq_n, .irq);
	can_bus_node u_can_bus_node (.tx_pin(can_tx_pin), .node_dom(node_dom), .rx_pin(can_rx_pin));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp
	// Waits for pready without a limit of its own; only the watchdog ends a stuck wait
	task xfer(input int w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w[0];
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick
	task pulse(input logic [15:0] m);
		@(posedge pclk);
		flag_events <= m;
		@(posedge pclk);
		flag_events <= 16'h0000;
		tick(1);
	endtask : pulse
	task test_done;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, flag_events, core_tx, node_dom} = '0;
		{fails, checked} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, IRQ_ENABLE_OFFSET, 0);
		cmp("enable reset", 32'h0000_0000, rd);
		xfer(0, OP_MODE_BASE + REG_STRIDE, 0);
		cmp("mode reset", 32'h0000_0000, rd);
		cmp("idle pins", 32'h0000_001F, {irqs, can_tx_pin});
		xfer(1, IRQ_ENABLE_OFFSET, 32'h0000_FFFF);
		xfer(0, IRQ_ENABLE_OFFSET, 0);
		cmp("enable read", 32'h0000_FFFD, rd);
		$display("test reset done");
		for (int b = 2; b < 16; b++) begin
			exp3 = (b >= 11 || b == 4) ? 3'b011 : (b >= 5) ? 3'b101 : 3'b110;
			pulse(16'h0001 << b);
			cmp("groups", exp3, irqs);
			cmp("irq", 1'b1, irq);
			xfer(1, IRQ_CLEAR_OFFSET, 32'h0000_0001 << b);
			tick(1);
			cmp("cleared", 3'b111, irqs);
		end
		xfer(1, IRQ_ENABLE_OFFSET, 32'h0000_FFDD);
		pulse(16'h0020);
		cmp("masked", 3'b111, irqs);
		xfer(1, IRQ_ENABLE_OFFSET, 32'h0000_FFFC);
		tick(2);
		cmp("gated", 3'b111, irqs);
		xfer(1, IRQ_ENABLE_OFFSET, 32'h0000_FFFD);
		tick(2);
		cmp("sticky", 3'b101, irqs);
		pulse(16'h7800);
		xfer(1, IRQ_CLEAR_OFFSET, 32'h0000_4000);
		xfer(0, IRQ_FLAGS_OFFSET, 0);
		cmp("flags", 32'h0000_0020, rd);
		pulse(16'h7800);
		xfer(1, IRQ_CLEAR_OFFSET, 32'h0000_1000);
		xfer(0, IRQ_FLAGS_OFFSET, 0);
		cmp("flags", 32'h0000_2820, rd);
		xfer(1, IRQ_CLEAR_OFFSET, 32'h0000_FFFF);
		tick(1);
		cmp("all clear", 3'b111, irqs);
		pulse(16'h0008);
		cmp("diag set", 3'b110, irqs);
		xfer(1, IRQ_FLAGS_OFFSET, 32'h0000_0008);
		tick(1);
		cmp("flag wr1c", 3'b111, irqs);
		xfer(0, IRQ_FLAGS_OFFSET, 0);
		cmp("flags read", 32'h0000_0000, {err, rd[30:0]});
		xfer(0, IRQ_CLEAR_OFFSET, 0);
		cmp("clear reads", 32'h0000_0000, {err, rd[30:0]});
		xfer(0, 8'h40, 0);
		cmp("unmapped", 32'h8000_0000, {err, rd[30:0]});
		$display("test interrupts done");
		xfer(1, OP_MODE_BASE, 32'h0000_0001);
		tick(1);
		cmp("run pins", 2'b10, can_tx_pin);
		xfer(0, OP_MODE_BASE, 0);
		cmp("run read", 32'h0000_0001, rd);
		xfer(1, OP_MODE_BASE, 32'h0000_0003);
		node_dom <= 2'b01;
		tick(4);
		cmp("listener", 4'b1110, {can_tx_pin, core_rx});
		xfer(1, OP_MODE_BASE, 32'h0000_0000);
		node_dom <= 2'b00;
		tick(1);
		cmp("stopped", 2'b11, can_tx_pin);
		xfer(1, OP_MODE_BASE + REG_STRIDE, 32'h0000_0005);
		xfer(1, OP_MODE_BASE, 32'h0000_0005);
		core_tx <= 2'b10;
		tick(4);
		cmp("loopback", 4'b1100, {can_tx_pin, core_rx});
		xfer(1, OP_MODE_BASE, 32'h0000_0001);
		core_tx <= 2'b01;
		tick(4);
		cmp("external", 4'b0101, {can_tx_pin, core_rx});
		$display("test modes done");
		test_done();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		test_done();
	end
endmodule : can_irq_mode_ctrl_bench
